// File: include/lat_defs.svh
// Register indices, reset values and field widths of the memory
// controller configuration bank. Assumes 32-bit APB, one word a register.
`ifndef LAT_DEFS_SVH
`define LAT_DEFS_SVH
// Register indices; byte address is four times the index
`define LAT_IDX_PRIO 16'hC009
`define LAT_IDX_STARVE 16'hC00A
`define LAT_IDX_PHY 16'hC01D
`define LAT_IDX_LMR 16'hC01E
`define LAT_IDX_EMR 16'hC01F
`define LAT_IDX_TIM1 16'hC020
`define LAT_IDX_TIM2 16'hC021
`define LAT_IDX_PAD_CLK 16'hD000
`define LAT_IDX_PAD_CKE 16'hD001
`define LAT_IDX_PAD_CS 16'hD002
`define LAT_IDX_PAD_WE 16'hD003
`define LAT_IDX_STATUS 16'hC0FF
// Field widths of each register (bits above read zero)
`define LAT_W_PRIO 6
`define LAT_W_STARVE 4
`define LAT_W_OPC 14
`define LAT_W_TIM1 24
`define LAT_W_TIM2 18
`define LAT_W_PAD 7
`define LAT_W_STATUS 16
// Reset values
`define LAT_RST_PRIO 6'h05
`define LAT_RST_STARVE 4'h4
`define LAT_RST_PHY 14'h2101
`define LAT_RST_LMR 14'h0034
`define LAT_RST_EMR 14'h0000
`define LAT_RST_TIM1 24'h33C30B
`define LAT_RST_TIM2 18'h0EE4B
`define LAT_RST_PAD 7'h10
// Timer bank size and width
`define LAT_NUM_TMR 8
`define LAT_TMR_W 6
`endif

// File: include/lat_pkg.sv
// Types of the memory controller configuration bank.
// Assumes lat_defs.svh gives the field widths.
package lat_pkg;
  // Queue priorities, queue 1 above queue 0
  typedef struct packed {
    logic [2:0] q1;
    logic [2:0] q0;
  } lat_prio_t;
  // First timing word
  typedef struct packed {
    logic [2:0] twr;
    logic [5:0] txsr;
    logic [3:0] tras;
    logic [10:0] trefi;
  } lat_tim1_t;
  // Second timing word
  typedef struct packed {
    logic large_dev;
    logic [1:0] trrd;
    logic [4:0] trfc;
    logic [2:0] trp;
    logic [2:0] trcd;
    logic [3:0] trc;
  } lat_tim2_t;
  // Pad properties of one pin group
  typedef struct packed {
    logic schmitt;
    logic slew;
    logic [1:0] drive;
    logic [1:0] pull;
    logic rx_en;
  } lat_pad_t;
  // Words handed to the physical layer and mode loader
  typedef struct packed {
    logic [13:0] phy;
    logic [13:0] lmr;
    logic [13:0] emr;
    logic large_dev;
  } lat_cfg_t;
  // Timer slots
  typedef enum {
    LAT_T_RC, LAT_T_RRD, LAT_T_RCD, LAT_T_RAS,
    LAT_T_RP, LAT_T_WR, LAT_T_XSR, LAT_T_RFC
  } lat_tmr_t;
endpackage

// File: hw/lat_regs.sv
// Configuration bank of the low-power DDR controller: arbiter,
// command timing guards, refresh pacing and pad properties.
// Assumes an APB master on pclk and memory clock equal to pclk.
// Functional notes
// - Two 3-bit queue priorities, zero lowest
// - Reset priorities: queue0 five, queue1 zero
// - Nonzero limit serves each queue within N
// - Limit zero disables guarantee; resets to four
// - Refresh interval 11-bit, resets to 779
// - Activate-to-precharge minimum, resets to 8
// - Self-refresh exit wait, resets to 39
// - Write recovery wait, resets to 1
// - Same-bank activate spacing, resets to 11
// - Activate-to-access delay, resets to 4
// - Precharge period before activate, resets 4
// - Refresh cycle wait, resets to 27
// - Bank-to-bank activate spacing, resets to 1
// - Bit 17 selects large device addressing
// - PHY control word resets to 0x2101
// - Mode opcode resets to 0x0034
// - Extended mode opcode resets to zero
// - Pad registers act while interface enabled
// - Drive strength field, resets to 8 mA
// - Pull field, resets to none
// - Schmitt, slew, receiver bits reset zero
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "lat_defs.svh"

module lat_regs #(
  parameter int ADDR_W = 18
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Queue arbitration
  input wire logic [1:0] q_req,
  input wire logic arb_take,
  output logic grant_valid,
  output logic grant_q1,
  // Command timing guards
  input wire logic cmd_act,
  input wire logic cmd_rdwr,
  input wire logic cmd_wr,
  input wire logic cmd_pre,
  input wire logic sr_exit,
  output logic act_ok,
  output logic rdwr_ok,
  output logic pre_ok,
  output logic refresh_req,
  output logic refresh_busy,
  // Physical layer and pads
  input wire logic mem_if_enable,
  output lat_pkg::lat_cfg_t cfg,
  output lat_pkg::lat_pad_t pad_clk,
  output lat_pkg::lat_pad_t pad_cke,
  output lat_pkg::lat_pad_t pad_cs,
  output lat_pkg::lat_pad_t pad_we
);

  // Programmed state
  lat_pkg::lat_prio_t prio; // Queue priorities
  logic [3:0] starve_lim; // Starvation limit
  logic [13:0] phy_word; // PHY control
  logic [13:0] lmr_opc; // Mode opcode
  logic [13:0] emr_opc; // Extended mode opcode
  lat_pkg::lat_tim1_t tim1; // First timing word
  lat_pkg::lat_tim2_t tim2; // Second timing word
  lat_pkg::lat_pad_t pad_r [4]; // Pad words, clk/cke/cs/we

  // Arbiter and timing state
  logic [3:0] wait0; // Grants to queue 1 while queue 0 waits
  logic [3:0] wait1; // Grants to queue 0 while queue 1 waits
  logic [10:0] refi_cnt; // Refresh interval countdown
  logic [`LAT_TMR_W-1:0] tmr [`LAT_NUM_TMR]; // Guard timers

  // Bus decode
  logic [15:0] idx; // Word index of the access
  logic hit; // Access maps to a register
  logic [31:0] rd_word; // Read value of the addressed word
  logic wr_en; // Write takes effect this edge
  logic [3:0] pad_sel; // One-hot pad register write
  logic starved0; // Queue 0 must be served next
  logic starved1; // Queue 1 must be served next
  logic pick1; // Arbiter picks queue 1
  logic [`LAT_NUM_TMR-1:0] tmr_load; // Timer restart strobes
  logic [`LAT_TMR_W-1:0] tmr_val [`LAT_NUM_TMR]; // Timer loads

  // Pad word, zero-extended to a bus word
  function automatic logic [31:0] padw(input lat_pkg::lat_pad_t p);
    padw = {{(32-`LAT_W_PAD){1'b0}}, p};
  endfunction

  // Starvation check for one queue
  function automatic logic starving(input logic req, input logic [3:0] w,
                                    input logic [3:0] lim);
    starving = req && (lim != 4'h0) && (w >= lim - 4'h1);
  endfunction

  // Wait counter update for one queue
  function automatic logic [3:0] next_wait(input logic req, input logic served,
                                           input logic [3:0] w);
    if (served || !req) begin
      next_wait = 4'h0;
    end else if (w != 4'hF) begin
      next_wait = w + 4'h1;
    end else begin
      next_wait = w;
    end
  endfunction

  // Address to register decode and read mux.
  // Every register is one aligned word; the two low address bits
  // must be zero or the access is refused with an error.
  // Reserved bits above each field read as zero, so software can
  // compare a read against what it wrote after masking the field.
  always_comb begin
    idx = paddr[17:2];
    hit = (paddr[1:0] == 2'b00);
    rd_word = 32'h0000_0000;
    unique case (idx)
      `LAT_IDX_PRIO: rd_word = {26'h0, prio};
      `LAT_IDX_STARVE: rd_word = {28'h0, starve_lim};
      `LAT_IDX_PHY: rd_word = {18'h0, phy_word};
      `LAT_IDX_LMR: rd_word = {18'h0, lmr_opc};
      `LAT_IDX_EMR: rd_word = {18'h0, emr_opc};
      `LAT_IDX_TIM1: rd_word = {8'h0, tim1};
      `LAT_IDX_TIM2: rd_word = {14'h0, tim2};
      `LAT_IDX_PAD_CLK: rd_word = padw(pad_r[0]);
      `LAT_IDX_PAD_CKE: rd_word = padw(pad_r[1]);
      `LAT_IDX_PAD_CS: rd_word = padw(pad_r[2]);
      `LAT_IDX_PAD_WE: rd_word = padw(pad_r[3]);
      // Live state: guards, last grant, wait counters
      `LAT_IDX_STATUS: rd_word = {16'h0, refresh_busy, act_ok, rdwr_ok,
                                  pre_ok, 3'h0, grant_q1, wait1, wait0};
      default: hit = 1'b0; // Unmapped word
    endcase
  end

  // Zero wait states; writes land at the access edge
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite && hit;

  // Read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= (hit && !pwrite) ? rd_word : 32'h0000_0000;
      pslverr <= !hit;
    end
  end

  // Arbiter configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio <= lat_pkg::lat_prio_t'(`LAT_RST_PRIO);
      starve_lim <= `LAT_RST_STARVE;
    end else if (wr_en) begin
      if (idx == `LAT_IDX_PRIO) begin
        prio <= lat_pkg::lat_prio_t'(pwdata[`LAT_W_PRIO-1:0]);
      end
      if (idx == `LAT_IDX_STARVE) begin
        starve_lim <= pwdata[`LAT_W_STARVE-1:0];
      end
    end
  end

  // PHY and mode register words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_word <= `LAT_RST_PHY;
      lmr_opc <= `LAT_RST_LMR;
      emr_opc <= `LAT_RST_EMR;
    end else if (wr_en) begin
      if (idx == `LAT_IDX_PHY) begin
        phy_word <= pwdata[`LAT_W_OPC-1:0];
      end
      if (idx == `LAT_IDX_LMR) begin
        lmr_opc <= pwdata[`LAT_W_OPC-1:0];
      end
      if (idx == `LAT_IDX_EMR) begin
        emr_opc <= pwdata[`LAT_W_OPC-1:0];
      end
    end
  end

  // Timing words; new counts apply to the next timer load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tim1 <= lat_pkg::lat_tim1_t'(`LAT_RST_TIM1);
      tim2 <= lat_pkg::lat_tim2_t'(`LAT_RST_TIM2);
    end else if (wr_en) begin
      if (idx == `LAT_IDX_TIM1) begin
        tim1 <= lat_pkg::lat_tim1_t'(pwdata[`LAT_W_TIM1-1:0]);
      end
      if (idx == `LAT_IDX_TIM2) begin
        tim2 <= lat_pkg::lat_tim2_t'(pwdata[`LAT_W_TIM2-1:0]);
      end
    end
  end

  // Pad register write select
  always_comb begin
    pad_sel = 4'h0;
    if (wr_en) begin
      pad_sel[0] = (idx == `LAT_IDX_PAD_CLK);
      pad_sel[1] = (idx == `LAT_IDX_PAD_CKE);
      pad_sel[2] = (idx == `LAT_IDX_PAD_CS);
      pad_sel[3] = (idx == `LAT_IDX_PAD_WE);
    end
  end

  // Pad words: 8 mA, no pull, all enables off at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        pad_r[i] <= lat_pkg::lat_pad_t'(`LAT_RST_PAD);
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pad_sel[i]) begin
          pad_r[i] <= lat_pkg::lat_pad_t'(pwdata[`LAT_W_PAD-1:0]);
        end
      end
    end
  end

  // Pads follow their words only while the interface is on;
  // otherwise they hold the reset properties so pins stay benign
  always_comb begin
    pad_clk = mem_if_enable ? pad_r[0] : lat_pkg::lat_pad_t'(`LAT_RST_PAD);
    pad_cke = mem_if_enable ? pad_r[1] : lat_pkg::lat_pad_t'(`LAT_RST_PAD);
    pad_cs = mem_if_enable ? pad_r[2] : lat_pkg::lat_pad_t'(`LAT_RST_PAD);
    pad_we = mem_if_enable ? pad_r[3] : lat_pkg::lat_pad_t'(`LAT_RST_PAD);
  end

  // Words for the physical layer and mode loader
  always_comb begin
    cfg.phy = phy_word;
    cfg.lmr = lmr_opc;
    cfg.emr = emr_opc;
    cfg.large_dev = tim2.large_dev;
  end

  // Queue selection
  always_comb begin
    starved0 = starving(q_req[0], wait0, starve_lim);
    starved1 = starving(q_req[1], wait1, starve_lim);
    if (starved0 && starved1) begin
      pick1 = (wait1 > wait0); // Longer waiter first; tie to queue 0
    end else if (starved0 || starved1) begin
      pick1 = starved1;
    end else begin
      // Higher value wins; tie to queue 0
      pick1 = q_req[1] && (!q_req[0] || (prio.q1 > prio.q0));
    end
  end

  // Grant register: one-cycle pulse per accepted transaction.
  // The granted queue is held between pulses so the engine can
  // read it late; only a new grant moves it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant_valid <= 1'b0;
      grant_q1 <= 1'b0;
    end else begin
      grant_valid <= arb_take && (q_req != 2'b00);
      if (arb_take && (q_req != 2'b00)) begin
        grant_q1 <= pick1;
      end
    end
  end

  // Starvation counters count only grants to the other queue.
  // They saturate rather than wrap, so a long wait never looks
  // like a fresh queue to the starvation check.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait0 <= 4'h0;
      wait1 <= 4'h0;
    end else if (arb_take && (q_req != 2'b00)) begin
      wait0 <= next_wait(q_req[0], !pick1, wait0);
      wait1 <= next_wait(q_req[1], pick1, wait1);
    end else begin
      wait0 <= q_req[0] ? wait0 : 4'h0;
      wait1 <= q_req[1] ? wait1 : 4'h0;
    end
  end

  // Refresh pacing; counter reloads from the live interval.
  // A new interval takes effect only at the next reload, so a
  // shortened interval can lag by up to one old period.
  // The period is the interval count plus one cycle for the pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refi_cnt <= 11'(`LAT_RST_TIM1 & 24'h0007FF); // Interval field only
      refresh_req <= 1'b0;
    end else if (refi_cnt == 11'h000) begin
      refi_cnt <= tim1.trefi;
      refresh_req <= 1'b1;
    end else begin
      refi_cnt <= refi_cnt - 11'h001;
      refresh_req <= 1'b0;
    end
  end

  // Timer restarts and their counts
  always_comb begin
    tmr_load = '0;
    tmr_load[lat_pkg::LAT_T_RC] = cmd_act;
    tmr_load[lat_pkg::LAT_T_RRD] = cmd_act;
    tmr_load[lat_pkg::LAT_T_RCD] = cmd_act;
    tmr_load[lat_pkg::LAT_T_RAS] = cmd_act;
    tmr_load[lat_pkg::LAT_T_RP] = cmd_pre;
    tmr_load[lat_pkg::LAT_T_WR] = cmd_wr;
    tmr_load[lat_pkg::LAT_T_XSR] = sr_exit;
    tmr_load[lat_pkg::LAT_T_RFC] = refresh_req;
    tmr_val[lat_pkg::LAT_T_RC] = {2'b00, tim2.trc};
    tmr_val[lat_pkg::LAT_T_RRD] = {4'h0, tim2.trrd};
    tmr_val[lat_pkg::LAT_T_RCD] = {3'h0, tim2.trcd};
    tmr_val[lat_pkg::LAT_T_RAS] = {2'b00, tim1.tras};
    tmr_val[lat_pkg::LAT_T_RP] = {3'h0, tim2.trp};
    tmr_val[lat_pkg::LAT_T_WR] = {3'h0, tim1.twr};
    tmr_val[lat_pkg::LAT_T_XSR] = tim1.txsr;
    tmr_val[lat_pkg::LAT_T_RFC] = {1'b0, tim2.trfc};
  end

  // Guard timers count down to zero after their command.
  // Single open-row view: same-bank and cross-bank spacing both
  // gate every activate, which is safe but not bank-aware.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `LAT_NUM_TMR; i++) begin
        tmr[i] <= '0;
      end
    end else begin
      for (int i = 0; i < `LAT_NUM_TMR; i++) begin
        if (tmr_load[i]) begin
          tmr[i] <= tmr_val[i];
        end else if (tmr[i] != '0) begin
          tmr[i] <= tmr[i] - 1'b1;
        end
      end
    end
  end

  // Command permissions from the timers.
  // These are advice only: a command issued early still reloads
  // its timers, so the engine must honour them itself.
  always_comb begin
    act_ok = (tmr[lat_pkg::LAT_T_RC] == '0) && (tmr[lat_pkg::LAT_T_RRD] == '0)
          && (tmr[lat_pkg::LAT_T_RP] == '0) && (tmr[lat_pkg::LAT_T_XSR] == '0)
          && (tmr[lat_pkg::LAT_T_RFC] == '0);
    rdwr_ok = (tmr[lat_pkg::LAT_T_RCD] == '0) && (tmr[lat_pkg::LAT_T_XSR] == '0)
           && (tmr[lat_pkg::LAT_T_RFC] == '0);
    pre_ok = (tmr[lat_pkg::LAT_T_RAS] == '0) && (tmr[lat_pkg::LAT_T_WR] == '0)
          && (tmr[lat_pkg::LAT_T_XSR] == '0);
    refresh_busy = (tmr[lat_pkg::LAT_T_RFC] != '0);
  end

endmodule

// File: dv/lat_engine_model.sv
// Model of the command engine facing the bank's arbiter and timers.
// Assumes the memory clock is pclk and the bench steers it by levels.
`timescale 1ns/1ps
module lat_engine_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench controls
  input wire logic arb_en,
  input wire logic act_go,
  // Advice from the bank
  input wire logic act_ok,
  // Requests to the bank
  output logic [1:0] q_req,
  output logic arb_take,
  output logic cmd_act
);
  // Both queues pend and every cycle is taken while enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_req <= 2'h0;
      arb_take <= 1'b0;
    end else begin
      q_req <= {arb_en, arb_en};
      arb_take <= arb_en;
    end
  end
  // One-cycle activate, held back until the guard allows it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_act <= 1'b0;
    end else begin
      cmd_act <= act_go && act_ok && !cmd_act;
    end
  end
endmodule

// File: dv/lat_regs_checker.sv
// Port checker of the configuration bank.
// Assumes it is bound into lat_regs with one clock domain.
`timescale 1ns/1ps
`include "lat_defs.svh"
module lat_regs_checker #(
  parameter int ADDR_W = 18
) (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  // Arbiter and timers
  input wire logic [1:0] q_req,
  input wire logic arb_take,
  input wire logic grant_valid,
  input wire logic grant_q1,
  input wire logic cmd_act,
  input wire logic act_ok,
  input wire logic refresh_req,
  input wire logic refresh_busy,
  // Pads
  input wire logic mem_if_enable,
  input wire lat_pkg::lat_pad_t pad_clk,
  input wire lat_pkg::lat_pad_t pad_cke,
  input wire lat_pkg::lat_pad_t pad_cs,
  input wire lat_pkg::lat_pad_t pad_we
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase of a write to the clock-enable pad word
  sequence s_cke_write;
    psel && penable && pwrite && paddr == {`LAT_IDX_PAD_CKE, 2'h0};
  endsequence
  // Refresh issued
  sequence s_refresh;
    refresh_req;
  endsequence
  a_grant_has_cause: assert property (grant_valid |-> $past(arb_take && q_req != 2'h0))
    else $error("grant without a request");
  a_grant_pending_only: assert property (grant_valid |->
    (grant_q1 ? $past(q_req[1]) : $past(q_req[0])))
    else $error("grant to an empty queue");
  a_grant_queue_held: assert property (!grant_valid |-> $stable(grant_q1))
    else $error("granted queue moved without a grant");
  a_act_guard_low: assert property (cmd_act |=> !act_ok)
    else $error("activate guard not raised");
  a_refresh_busy: assert property (s_refresh |=> refresh_busy)
    else $error("refresh wait not started");
  a_refresh_spacing: assert property (s_refresh |=> !refresh_req [*8])
    else $error("refresh issued too soon");
  a_pads_idle: assert property (!mem_if_enable |-> pad_clk == 7'h10 && pad_cke == 7'h10
    && pad_cs == 7'h10 && pad_we == 7'h10)
    else $error("pad word shown while disabled");
  a_pad_write: assert property (s_cke_write ##1 mem_if_enable |->
    pad_cke == $past(pwdata[6:0]))
    else $error("pad word not applied");
endmodule
bind lat_regs lat_regs_checker #(.ADDR_W(ADDR_W)) lat_regs_checker_inst (.*);

// File: dv/test_lpddr_arbiter_timing_pad_config.sv
// Self-checking bench of the configuration bank over APB.
// Assumes the engine model drives arbiter and activate inputs.
`timescale 1ns/1ps
`include "lat_defs.svh"
module test_lpddr_arbiter_timing_pad_config;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, arb_en, act_go;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd, na, nr, comparisons, n_mismatch;
  logic er, arb_take, grant_valid, grant_q1, cmd_act, act_ok, rdwr_ok, mem_if_enable;
  logic pre_ok, refresh_req, refresh_busy;
  logic [1:0] q_req;
  logic [6:0] pv;
  lat_pkg::lat_cfg_t cfg;
  lat_pkg::lat_pad_t pad_clk, pad_cke, pad_cs, pad_we;
  lat_pkg::lat_pad_t pd [4];
  // Register table: index, reset value, writable mask
  logic [15:0] ix [11] = '{`LAT_IDX_PRIO, `LAT_IDX_STARVE, `LAT_IDX_PHY, `LAT_IDX_LMR,
    `LAT_IDX_EMR, `LAT_IDX_TIM1, `LAT_IDX_TIM2, `LAT_IDX_PAD_CLK, `LAT_IDX_PAD_CKE,
    `LAT_IDX_PAD_CS, `LAT_IDX_PAD_WE};
  logic [31:0] rv [11] = '{{26'h0, 3'h0, 3'h5}, 32'h4, 32'h2101, 32'h34, 32'h0,
    {8'h0, 3'h1, 6'h27, 4'h8, 11'h30B}, {14'h0, 1'b0, 2'h1, 5'h1B, 3'h4, 3'h4, 4'hB},
    32'h10, 32'h10, 32'h10, 32'h10};
  logic [31:0] mk [11] = '{32'h3F, 32'hF, 32'h3FFF, 32'h3FFF, 32'h3FFF, 32'hFFFFFF,
    32'h3FFFF, 32'h7F, 32'h7F, 32'h7F, 32'h7F};
  // Arbiter cases: priorities, limit, grant pattern first grant in msb
  logic [31:0] ap [3] = '{32'h31, 32'h31, 32'h17};
  logic [31:0] al [3] = '{32'h4, 32'h0, 32'h4};
  logic [7:0] ag [3] = '{8'hEE, 8'hFF, 8'h11};
  assign pd = '{pad_clk, pad_cke, pad_cs, pad_we};
  lat_regs lat_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .q_req(q_req), .arb_take(arb_take), .grant_valid(grant_valid),
    .grant_q1(grant_q1), .cmd_act(cmd_act), .cmd_rdwr(1'b0), .cmd_wr(1'b0),
    .cmd_pre(1'b0), .sr_exit(1'b0), .act_ok(act_ok), .rdwr_ok(rdwr_ok), .pre_ok(pre_ok),
    .refresh_req(refresh_req), .refresh_busy(refresh_busy), .mem_if_enable(mem_if_enable),
    .cfg(cfg), .pad_clk(pad_clk), .pad_cke(pad_cke), .pad_cs(pad_cs), .pad_we(pad_we));
  lat_engine_model lat_engine_model_inst (.pclk(pclk), .presetn(presetn), .arb_en(arb_en),
    .act_go(act_go), .act_ok(act_ok), .q_req(q_req), .arb_take(arb_take),
    .cmd_act(cmd_act));
  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard, far beyond the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    wrap_up();
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, arb_en, act_go, mem_if_enable} = 6'h0;
    paddr = 18'h0;
    pwdata = 32'h0;
    comparisons = 32'h0;
    n_mismatch = 32'h0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk("cfg phy lmr", {4'h0, cfg.phy, cfg.lmr}, {4'h0, 14'h2101, 14'h0034});
    chk("cfg emr dev", {17'h0, cfg.emr, cfg.large_dev}, 32'h0);
    for (int i = 0; i < 11; i++) begin
      apb(1'b0, ix[i], 32'h0, rd, er);
      chk("reset value", rd, rv[i]);
    end
    for (int i = 0; i < 11; i++) begin
      apb(1'b1, ix[i], 32'hFFFFFFFF, rd, er);
      apb(1'b0, ix[i], 32'h0, rd, er);
      chk("field width", rd, mk[i]);
    end
    apb(1'b0, 16'hC00B, 32'h0, rd, er);
    chk("unmapped error", {31'h0, er}, 32'h1);
    // Short refresh interval, tRC 5 above tRRD 1, tRCD 3, large device
    apb(1'b1, `LAT_IDX_TIM1, {8'h0, 3'h1, 6'h2, 4'h3, 11'h014}, rd, er);
    apb(1'b1, `LAT_IDX_TIM2, {14'h0, 1'b1, 2'h1, 5'h3, 3'h2, 3'h3, 4'h5}, rd, er);
    @(negedge pclk);
    chk("large device", {31'h0, cfg.large_dev}, 32'h1);
    $display("test registers done");
    // Start just after a refresh so its wait cannot mask the guards
    do @(negedge pclk); while (refresh_req !== 1'b1);
    repeat (4) @(posedge pclk);
    act_go <= 1'b1;
    do @(negedge pclk); while (cmd_act !== 1'b1);
    @(posedge pclk);
    act_go <= 1'b0;
    na = 32'h0;
    nr = 32'h0;
    repeat (8) begin
      @(negedge pclk);
      na += {31'h0, act_ok === 1'b0};
      nr += {31'h0, rdwr_ok === 1'b0};
    end
    chk("activate hold", na, 32'h5);
    chk("access hold", nr, 32'h3);
    $display("test timers done");
    @(posedge pclk);
    mem_if_enable <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      pv = {i[0], i[1], i[1:0], i[1:0], ~i[0]};
      apb(1'b1, `LAT_IDX_PAD_CLK + i[15:0], {25'h0, pv}, rd, er);
      @(negedge pclk);
      chk("pad enabled", {25'h0, pd[i]}, {25'h0, pv});
    end
    @(posedge pclk);
    mem_if_enable <= 1'b0;
    @(negedge pclk);
    chk("pad disabled", {25'h0, pd[3]}, 32'h10);
    $display("test pads done");
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, `LAT_IDX_PRIO, ap[c], rd, er);
      apb(1'b1, `LAT_IDX_STARVE, al[c], rd, er);
      arb_en <= 1'b1;
      for (int g = 7; g >= 0; g--) begin
        do @(negedge pclk); while (grant_valid !== 1'b1);
        chk("granted queue", {31'h0, grant_q1}, {31'h0, ag[c][g]});
      end
      @(posedge pclk);
      arb_en <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    $display("test arbiter done");
    do @(negedge pclk); while (refresh_req !== 1'b1);
    na = 32'h0;
    do begin
      @(negedge pclk);
      na++;
    end while (refresh_req !== 1'b1);
    chk("refresh gap", na, 32'h15);
    $display("test refresh done");
    wrap_up();
  end
endmodule
